/* File: gic_pkg.sv */
// Constants shared by the pin port and interrupt controller
package gic_pkg;

  // Register indices carried in link command slot 1
  localparam logic [6:0] IDX_PIN_LEVEL = 7'h5A;
  localparam logic [6:0] IDX_PIN_DIR = 7'h5C;
  localparam logic [6:0] IDX_RISE_EN = 7'h5E;
  localparam logic [6:0] IDX_FALL_EN = 7'h60;
  localparam logic [6:0] IDX_STATUS = 7'h62;
  localparam logic [6:0] IDX_FEATURE1 = 7'h6A;
  localparam logic [6:0] IDX_EXTRA_IRQ = 7'h70;

  // Values after reset
  localparam logic [15:0] RST_REG16 = 16'h0000;

  // Status / enable bit positions; pins use bits 0..9
  localparam int SRC_OVERLOAD = 10;
  localparam int SRC_CLIP = 11;
  localparam int SRC_ADC_READY = 12;
  localparam int SRC_TOUCH_XP = 13;
  localparam int SRC_TOUCH_XM = 14;

  // Feature register fields
  localparam int FEAT_OVERLOAD_FLAG = 0;
  localparam int FEAT_LINK_IRQ_EN = 1;
  localparam int FEAT_HP_ENABLE = 6;

  // Extra interrupt register fields
  localparam int XTRA_CLIP_LEFT = 0;
  localparam int XTRA_CLIP_RIGHT = 1;
  localparam int XTRA_CLIP_GROUND = 2;

  // Frame bit positions, counted from the first tag bit of slot 0
  localparam logic [7:0] POS_FIRST = 8'h00;
  localparam logic [7:0] POS_TAG_SLOT1 = 8'h01;
  localparam logic [7:0] POS_TAG_SLOT2 = 8'h02;
  localparam logic [7:0] POS_TAG_SLOT12 = 8'h0C;
  localparam logic [7:0] POS_IDX_FIRST = 8'h11;
  localparam logic [7:0] POS_IDX_LAST = 8'h17;
  localparam logic [7:0] POS_DATA_FIRST = 8'h24;
  localparam logic [7:0] POS_DATA_LAST = 8'h33;
  localparam logic [7:0] POS_DECODE = 8'h37;
  localparam logic [7:0] POS_SLOT12_INT = 8'hFF;

  // Reference clock cycles per half bit clock period
  localparam logic [7:0] LINK_HALF_CYC = 8'h08;

  typedef enum logic [1:0] {
    WK_IDLE = 2'b00,
    WK_WAIT_HIGH = 2'b01,
    WK_WAIT_LOW = 2'b10
  } gic_wake_t;

endpackage

/* File: gic_sync3.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gic_sync3 #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } gic_sync_t;

  gic_sync_t st_reg;
  gic_sync_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second; q moves once stages two and three agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.q = (st_reg.s2 & st_reg.s3) | (st_reg.q & (st_reg.s2 | st_reg.s3));
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.q;

endmodule // gic_sync3

/* File: gic_gpio_irq.sv */
// General-purpose pins, edge interrupt controller and link register access
`timescale 1ns/1ps
module gic_gpio_irq #(
  parameter int NUM_PINS = 10,
  parameter logic [7:0] LINK_HALF = gic_pkg::LINK_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [NUM_PINS-1:0] gpio_in,
  output logic [NUM_PINS-1:0] gpio_out,
  output logic [NUM_PINS-1:0] gpio_oe,
  input wire logic audio_overload,
  input wire logic clip_left,
  input wire logic clip_right,
  input wire logic clip_ground,
  input wire logic adc_ready,
  input wire logic touch_x_plus_line,
  input wire logic touch_x_minus_line,
  input wire logic link_power_down,
  input wire logic link_sync,
  input wire logic link_sdata_out,
  output logic link_bit_clk,
  output logic link_sdata_in,
  output logic interrupt_output_pin
);

  localparam int NSYNC = NUM_PINS + 9;

  typedef struct packed {
    logic bclk;
    logic [7:0] div;
    logic [7:0] pos;
    logic framed;
    logic start_pend;
    logic sync_prev;
    logic [55:0] rx;
    logic sdi;
    logic tx_resp;
    logic [6:0] tx_idx;
    logic [15:0] tx_data;
    logic resp_pend;
    logic [6:0] resp_idx;
    logic [15:0] resp_data;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] dir;
    logic [15:0] rise_en;
    logic [15:0] fall_en;
    logic [15:0] status;
    logic [15:0] src_prev;
    logic link_interrupt_enable;
    logic headphone_driver_enable;
    logic input_overload_flag;
    logic irq;
    gic_pkg::gic_wake_t wake;
  } gic_state_t;

  gic_state_t st_reg;
  gic_state_t st_next;

  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sync_q;
  logic [NUM_PINS-1:0] pins;
  logic ovl_s;
  logic [2:0] clip_s;
  logic adc_s;
  logic txp_s;
  logic txm_s;
  logic sync_s;
  logic sdo_s;
  logic [2:0] clip_flags;
  logic [15:0] src;
  logic [15:0] edges;
  logic [15:0] clr;
  logic [15:0] rdata;
  logic [55:0] rxn;
  logic rise_evt;
  logic fall_evt;
  logic cmd_ok;
  logic cmd_rd;
  logic cmd_wr;
  logic [6:0] cmd_idx;
  logic [15:0] cmd_data;
  logic [7:0] pnext;
  logic [7:0] off_idx;
  logic [7:0] off_data;
  logic tx_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Every outside level except link_power_down passes the pin synchroniser
  assign sync_in = {link_sdata_out, link_sync, touch_x_minus_line, touch_x_plus_line,
                    adc_ready, clip_ground, clip_right, clip_left, audio_overload, gpio_in};

  gic_sync3 #(
    .W(NSYNC)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din(sync_in),
    .dout(sync_q)
  );

  assign pins = sync_q[NUM_PINS-1:0];
  assign ovl_s = sync_q[NUM_PINS];
  assign clip_s = sync_q[NUM_PINS+3:NUM_PINS+1];
  assign adc_s = sync_q[NUM_PINS+4];
  assign txp_s = sync_q[NUM_PINS+5];
  assign txm_s = sync_q[NUM_PINS+6];
  assign sync_s = sync_q[NUM_PINS+7];
  assign sdo_s = sync_q[NUM_PINS+8];

  ////////////////////////////////////////////////////////////////////////////
  // Register read data
  always_comb begin
    rdata = 16'h0000;
    unique case (cmd_idx)
      gic_pkg::IDX_PIN_LEVEL: rdata[NUM_PINS-1:0] = pins;
      gic_pkg::IDX_PIN_DIR: rdata[NUM_PINS-1:0] = st_reg.dir;
      gic_pkg::IDX_RISE_EN: rdata = st_reg.rise_en;
      gic_pkg::IDX_FALL_EN: rdata = st_reg.fall_en;
      gic_pkg::IDX_STATUS: rdata = st_reg.status;
      gic_pkg::IDX_FEATURE1: begin
        rdata[gic_pkg::FEAT_OVERLOAD_FLAG] = st_reg.input_overload_flag;
        rdata[gic_pkg::FEAT_LINK_IRQ_EN] = st_reg.link_interrupt_enable;
        rdata[gic_pkg::FEAT_HP_ENABLE] = st_reg.headphone_driver_enable;
      end
      gic_pkg::IDX_EXTRA_IRQ: begin
        rdata[gic_pkg::XTRA_CLIP_LEFT] = clip_flags[0];
        rdata[gic_pkg::XTRA_CLIP_RIGHT] = clip_flags[1];
        rdata[gic_pkg::XTRA_CLIP_GROUND] = clip_flags[2];
      end
      default: rdata = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing serial bit for the frame position about to start
  always_comb begin
    off_idx = gic_pkg::POS_IDX_LAST - pnext;
    off_data = gic_pkg::POS_DATA_LAST - pnext;
    tx_bit = 1'b0;
    if (pnext == gic_pkg::POS_FIRST) begin
      tx_bit = 1'b1;
    end else if (pnext == gic_pkg::POS_TAG_SLOT1 || pnext == gic_pkg::POS_TAG_SLOT2) begin
      tx_bit = st_next.tx_resp;
    end else if (pnext == gic_pkg::POS_TAG_SLOT12) begin
      tx_bit = st_reg.link_interrupt_enable;
    end else if (pnext >= gic_pkg::POS_IDX_FIRST && pnext <= gic_pkg::POS_IDX_LAST) begin
      tx_bit = st_next.tx_idx[off_idx[2:0]];
    end else if (pnext >= gic_pkg::POS_DATA_FIRST && pnext <= gic_pkg::POS_DATA_LAST) begin
      tx_bit = st_next.tx_data[off_data[3:0]];
    end else if (pnext == gic_pkg::POS_SLOT12_INT) begin
      tx_bit = st_reg.link_interrupt_enable & st_reg.irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_next = st_reg;
    pnext = st_reg.pos + 8'h01;
    rise_evt = 1'b0;
    fall_evt = 1'b0;
    rxn = {st_reg.rx[54:0], sdo_s};
    cmd_ok = rxn[55] & rxn[54] & (rxn[41:40] == 2'b00);
    cmd_rd = rxn[39];
    cmd_idx = rxn[38:32];
    cmd_data = rxn[19:4];
    cmd_wr = 1'b0;
    clr = 16'h0000;

    // Bit clock divider; it stands low while the link is powered down
    if (link_power_down) begin
      st_next.bclk = 1'b0;
      st_next.div = 8'h00;
      st_next.framed = 1'b0;
      st_next.start_pend = 1'b0;
    end else if (st_reg.div == LINK_HALF - 8'h01) begin
      st_next.div = 8'h00;
      st_next.bclk = ~st_reg.bclk;
      rise_evt = ~st_reg.bclk;
      fall_evt = st_reg.bclk;
    end else begin
      st_next.div = st_reg.div + 8'h01;
    end

    // Rising bit clock edge: advance frame position and drive the next bit
    if (rise_evt) begin
      if (st_reg.start_pend) begin
        pnext = gic_pkg::POS_FIRST;
        st_next.start_pend = 1'b0;
        st_next.framed = 1'b1;
        st_next.tx_resp = st_reg.resp_pend;
        st_next.tx_idx = st_reg.resp_idx;
        st_next.tx_data = st_reg.resp_data;
        st_next.resp_pend = 1'b0;
      end else if (st_reg.pos == gic_pkg::POS_SLOT12_INT) begin
        st_next.framed = 1'b0;
      end
      if (st_reg.start_pend || st_reg.framed) begin
        st_next.pos = pnext;
      end
      st_next.sdi = (st_reg.start_pend || (st_reg.framed && st_reg.pos != gic_pkg::POS_SLOT12_INT))
                    ? tx_bit : 1'b0;
    end

    // Falling edge: sample frame sync and command bits
    if (fall_evt) begin
      st_next.sync_prev = sync_s;
      if (sync_s && !st_reg.sync_prev) begin
        st_next.start_pend = 1'b1;
      end
      if (st_reg.framed && st_reg.pos <= gic_pkg::POS_DECODE) begin
        st_next.rx = rxn;
        if (st_reg.pos == gic_pkg::POS_DECODE && cmd_ok) begin
          if (cmd_rd) begin
            st_next.resp_pend = 1'b1;
            st_next.resp_idx = cmd_idx;
            st_next.resp_data = rdata;
          end else begin
            cmd_wr = rxn[53];
          end
        end
      end
    end

    // Register writes; unmapped indices are ignored
    if (cmd_wr) begin
      unique case (cmd_idx)
        gic_pkg::IDX_PIN_LEVEL: st_next.pin_out = cmd_data[NUM_PINS-1:0];
        gic_pkg::IDX_PIN_DIR: st_next.dir = cmd_data[NUM_PINS-1:0];
        gic_pkg::IDX_RISE_EN: st_next.rise_en = cmd_data;
        gic_pkg::IDX_FALL_EN: st_next.fall_en = cmd_data;
        gic_pkg::IDX_STATUS: clr = cmd_data;
        gic_pkg::IDX_FEATURE1: begin
          st_next.link_interrupt_enable = cmd_data[gic_pkg::FEAT_LINK_IRQ_EN];
          st_next.headphone_driver_enable = cmd_data[gic_pkg::FEAT_HP_ENABLE];
          if (cmd_data[gic_pkg::FEAT_OVERLOAD_FLAG]) begin
            st_next.input_overload_flag = 1'b0;
          end
        end
        default: clr = 16'h0000;
      endcase
    end

    // Overload flag is sticky; a new overload wins over its clear
    if (ovl_s) begin
      st_next.input_overload_flag = 1'b1;
    end

    // Edge detection on the reference clock keeps working with the bit clock stopped
    src = 16'h0000;
    src[NUM_PINS-1:0] = pins;
    src[gic_pkg::SRC_OVERLOAD] = ovl_s;
    src[gic_pkg::SRC_CLIP] = |clip_flags;
    src[gic_pkg::SRC_ADC_READY] = adc_s;
    src[gic_pkg::SRC_TOUCH_XP] = txp_s;
    src[gic_pkg::SRC_TOUCH_XM] = txm_s;
    st_next.src_prev = src;
    edges = (src & ~st_reg.src_prev & st_reg.rise_en) | (~src & st_reg.src_prev & st_reg.fall_en);
    // Set wins over a clear arriving in the same cycle
    st_next.status = (st_reg.status & ~clr) | edges;
    st_next.irq = |st_next.status;

    // Wake signalling while the bit clock is stopped
    unique case (st_reg.wake)
      gic_pkg::WK_IDLE: begin
        if (link_power_down && st_reg.link_interrupt_enable && st_next.irq && !st_reg.irq) begin
          st_next.wake = gic_pkg::WK_WAIT_HIGH;
        end
      end
      gic_pkg::WK_WAIT_HIGH: begin
        if (sync_s) begin
          st_next.wake = gic_pkg::WK_WAIT_LOW;
        end
      end
      gic_pkg::WK_WAIT_LOW: begin
        if (!sync_s) begin
          st_next.wake = gic_pkg::WK_IDLE;
        end
      end
      default: st_next.wake = gic_pkg::WK_IDLE;
    endcase
    if (st_next.wake != gic_pkg::WK_IDLE) begin
      st_next.sdi = 1'b1;
    end else if (link_power_down) begin
      st_next.sdi = 1'b0;
    end
  end

  // Clip flags only report while the headphone driver is on
  assign clip_flags = clip_s & {3{st_reg.headphone_driver_enable}};

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.rise_en <= gic_pkg::RST_REG16;
      st_reg.fall_en <= gic_pkg::RST_REG16;
      st_reg.status <= gic_pkg::RST_REG16;
      st_reg.wake <= gic_pkg::WK_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state
  assign gpio_out = st_reg.pin_out;
  assign gpio_oe = st_reg.dir;
  assign link_bit_clk = st_reg.bclk;
  assign link_sdata_in = st_reg.sdi;
  assign interrupt_output_pin = st_reg.irq;

endmodule // gic_gpio_irq

/* File: gic_host.sv */
// Link controller model that frames commands and captures answers
`timescale 1ns/1ps
module gic_host (
  input wire logic ref_clk,
  input wire logic link_bit_clk,
  input wire logic link_sdata_in,
  output logic link_sync,
  output logic link_sdata_out
);
  logic [255:0] rx;

  initial begin
    link_sync = 1'h0;
    link_sdata_out = 1'h0;
    rx = '0;
  end

  ////////////////////////////////////////////////////////////
  // Bit p of tx goes out at frame position p; data moves on the clock fall after a bit clock rise
  task automatic frame(input logic [255:0] tx);
    @(posedge link_bit_clk);
    @(negedge ref_clk);
    link_sync <= 1'h1;
    for (int p = 0; p < 256; p++) begin
      @(posedge link_bit_clk);
      @(negedge ref_clk);
      link_sdata_out <= tx[p];
      if (p == 16) begin
        link_sync <= 1'h0;
      end
      @(negedge link_bit_clk);
      rx[p] = link_sdata_in;
    end
    @(posedge link_bit_clk);
    @(negedge ref_clk);
    link_sdata_out <= 1'h0;
  endtask

  // Bit clock is stopped, so the sync pulse is timed on the reference clock
  task automatic wake_ack();
    @(negedge ref_clk);
    link_sync <= 1'h1;
    repeat (8) @(negedge ref_clk);
    link_sync <= 1'h0;
  endtask
endmodule // gic_host

/* File: gic_gpio_irq_assertions.sv */
// Port-level checker for the pin port and interrupt controller
`timescale 1ns/1ps
module gic_gpio_irq_chk #(
  parameter int NUM_PINS = 10,
  parameter logic [7:0] LINK_HALF = gic_pkg::LINK_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [NUM_PINS-1:0] gpio_in,
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [NUM_PINS-1:0] gpio_oe,
  input wire logic audio_overload,
  input wire logic clip_left,
  input wire logic clip_right,
  input wire logic clip_ground,
  input wire logic adc_ready,
  input wire logic touch_x_plus_line,
  input wire logic touch_x_minus_line,
  input wire logic link_power_down,
  input wire logic link_sync,
  input wire logic link_sdata_out,
  input wire logic link_bit_clk,
  input wire logic link_sdata_in,
  input wire logic interrupt_output_pin
);
  logic [NUM_PINS+6:0] src_now;
  logic [NUM_PINS+6:0] src_q;
  logic [3:0] quiet_cnt;
  logic [3:0] sync_age;
  logic [7:0] held;
  logic clk_q;
  logic armed;

  assign src_now = {gpio_in, audio_overload, clip_left, clip_right, clip_ground, adc_ready, touch_x_plus_line,
    touch_x_minus_line};

  // quiet_cnt and sync_age saturate so a long quiet spell never wraps into a false cause
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      src_q <= '0;
      quiet_cnt <= 4'hF;
      sync_age <= 4'hF;
      held <= 8'h00;
      clk_q <= 1'h0;
      armed <= 1'h0;
    end else begin
      src_q <= src_now;
      quiet_cnt <= (src_now != src_q) ? 4'h0 : ((quiet_cnt == 4'hF) ? 4'hF : quiet_cnt + 4'h1);
      sync_age <= link_sync ? 4'h0 : ((sync_age == 4'hF) ? 4'hF : sync_age + 4'h1);
      clk_q <= link_bit_clk;
      held <= (link_bit_clk != clk_q) ? 8'h01 : held + 8'h01;
      armed <= link_power_down ? 1'h0 : ((link_bit_clk != clk_q) ? 1'h1 : armed);
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence pd_long;
    link_power_down [*8];
  endsequence
  sequence wake_drop;
    link_power_down && $fell(link_sdata_in);
  endsequence
  sequence sdi_move;
    $changed(link_sdata_in) && !link_power_down && !$past(link_power_down, 2);
  endsequence

  chk_irq_cause: assert property ($rose(interrupt_output_pin) |-> quiet_cnt <= 4'hA)
    else $error("interrupt rose without a source change");
  chk_wake_cause: assert property (link_power_down && $rose(link_sdata_in) |-> interrupt_output_pin)
    else $error("wake line rose without interrupt");
  chk_wake_hold: assert property (wake_drop |-> sync_age <= 4'hA)
    else $error("wake line dropped before sync seen");
  chk_bclk_half: assert property ($changed(link_bit_clk) && armed && !link_power_down |-> held == LINK_HALF)
    else $error("bit clock half period wrong");
  chk_bclk_stop: assert property (pd_long |-> !link_bit_clk)
    else $error("bit clock runs in power down");
  chk_pins_on_cmd: assert property ($changed(gpio_oe) || $changed(gpio_out) |-> !link_bit_clk && !link_power_down)
    else $error("pin control changed outside a command");
  chk_irq_sticky: assert property ($fell(interrupt_output_pin) |-> !link_bit_clk && !link_power_down)
    else $error("interrupt dropped without a clear");
  chk_sdi_on_rise: assert property (sdi_move |-> $rose(link_bit_clk))
    else $error("serial answer changed off a bit clock rise");
endmodule // gic_gpio_irq_chk

bind gic_gpio_irq gic_gpio_irq_chk #(.NUM_PINS(NUM_PINS), .LINK_HALF(LINK_HALF)) u_gic_gpio_irq_chk (
  .ref_clk(ref_clk), .nrst(nrst), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
  .audio_overload(audio_overload), .clip_left(clip_left), .clip_right(clip_right), .clip_ground(clip_ground),
  .adc_ready(adc_ready), .touch_x_plus_line(touch_x_plus_line), .touch_x_minus_line(touch_x_minus_line),
  .link_power_down(link_power_down), .link_sync(link_sync), .link_sdata_out(link_sdata_out),
  .link_bit_clk(link_bit_clk), .link_sdata_in(link_sdata_in), .interrupt_output_pin(interrupt_output_pin));

/* File: gic_gpio_irq_test.sv */
// Self-checking bench for the pin port and interrupt controller
`timescale 1ns/1ps
module gic_gpio_irq_test;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic pd = 1'h0;
  logic ovl = 1'h0;
  logic clp_l = 1'h0;
  logic clp_r = 1'h0;
  logic clp_g = 1'h0;
  logic adc = 1'h0;
  logic txp = 1'h0;
  logic txm = 1'h0;
  logic [9:0] pin_ext = 10'h204;
  logic [9:0] gpio_in;
  logic [9:0] gpio_out;
  logic [9:0] gpio_oe;
  logic bclk;
  logic sdi;
  logic sync;
  logic sdo;
  logic irq;
  logic [15:0] d;
  int fail_count = 0;
  int samples_checked = 0;

  always #50 ref_clk = ~ref_clk;
  // Device wins where it drives, board level elsewhere
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & pin_ext);

  gic_gpio_irq #(.LINK_HALF(8'h06)) u_gic_gpio_irq (.ref_clk(ref_clk), .nrst(nrst), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .audio_overload(ovl), .clip_left(clp_l), .clip_right(clp_r),
    .clip_ground(clp_g), .adc_ready(adc), .touch_x_plus_line(txp), .touch_x_minus_line(txm),
    .link_power_down(pd), .link_sync(sync), .link_sdata_out(sdo), .link_bit_clk(bclk),
    .link_sdata_in(sdi), .interrupt_output_pin(irq));
  gic_host u_gic_host (.ref_clk(ref_clk), .link_bit_clk(bclk), .link_sdata_in(sdi), .link_sync(sync),
    .link_sdata_out(sdo));

  ////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [255:0] cmd(input logic is_read, input logic [6:0] idx, input logic [15:0] dat);
    logic [255:0] t;
    t = '0;
    t[0] = 1'h1;
    t[1] = 1'h1;
    t[2] = ~is_read;
    t[16] = is_read;
    for (int i = 0; i < 16; i++) begin
      t[36+i] = dat[15-i];
      if (i < 7) begin
        t[17+i] = idx[6-i];
      end
    end
    return t;
  endfunction

  task automatic wr(input logic [6:0] idx, input logic [15:0] dat);
    u_gic_host.frame(cmd(1'h0, idx, dat));
  endtask

  // Answer arrives in the frame after the command; an empty frame carries it
  task automatic rd(input logic [6:0] idx, output logic [15:0] dat);
    logic [6:0] echo;
    u_gic_host.frame(cmd(1'h1, idx, 16'h0000));
    u_gic_host.frame('0);
    for (int i = 0; i < 16; i++) begin
      dat[15-i] = u_gic_host.rx[36+i];
      if (i < 7) begin
        echo[6-i] = u_gic_host.rx[17+i];
      end
    end
    check("tag", {13'h0000, u_gic_host.rx[0], u_gic_host.rx[1], u_gic_host.rx[2]}, 16'h0007);
    check("echo", {9'h000, echo}, {9'h000, idx});
  endtask

  // Settle time covers synchroniser, status and pin stages
  task automatic set_src(input logic v);
    @(negedge ref_clk);
    pin_ext = {10{v}};
    ovl = v;
    clp_l = v;
    clp_r = v;
    clp_g = v;
    adc = v;
    txp = v;
    txm = v;
    repeat (12) @(negedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic test_reset();
    check("oe_rst", {6'h00, gpio_oe}, 16'h0000);
    check("irq_rst", {15'h0000, irq}, 16'h0000);
    rd(7'h7E, d);
    check("unmapped", d, 16'h0000);
  endtask

  task automatic test_pins();
    wr(gic_pkg::IDX_PIN_DIR, 16'h0003);
    wr(gic_pkg::IDX_PIN_LEVEL, 16'h0101);
    check("oe", {6'h00, gpio_oe}, 16'h0003);
    check("out", {6'h00, gpio_out}, 16'h0101);
    rd(gic_pkg::IDX_PIN_LEVEL, d);
    check("level", d, 16'h0205);
  endtask

  // Pins 0 and 1 are outputs here, so their edges never reach the status
  task automatic test_edges();
    wr(gic_pkg::IDX_RISE_EN, 16'h2AAA);
    wr(gic_pkg::IDX_FALL_EN, 16'h5555);
    set_src(1'h1);
    check("irq_up", {15'h0000, irq}, 16'h0001);
    rd(gic_pkg::IDX_STATUS, d);
    check("rise", d, 16'h20A8);
    wr(gic_pkg::IDX_STATUS, 16'h0008);
    set_src(1'h0);
    rd(gic_pkg::IDX_STATUS, d);
    check("fall", d, 16'h75F4);
    wr(gic_pkg::IDX_STATUS, 16'hFFFF);
    repeat (12) @(negedge ref_clk);
    check("irq_clr", {15'h0000, irq}, 16'h0000);
  endtask

  task automatic test_clip();
    wr(gic_pkg::IDX_FEATURE1, 16'h0040);
    wr(gic_pkg::IDX_RISE_EN, 16'h0800);
    @(negedge ref_clk);
    clp_r = 1'h1;
    repeat (12) @(negedge ref_clk);
    rd(gic_pkg::IDX_EXTRA_IRQ, d);
    check("extra", d, 16'h0002);
    rd(gic_pkg::IDX_STATUS, d);
    check("clip", d, 16'h0800);
    rd(gic_pkg::IDX_FEATURE1, d);
    check("feature", d, 16'h0041);
    wr(gic_pkg::IDX_FEATURE1, 16'h0041);
    rd(gic_pkg::IDX_FEATURE1, d);
    check("input_overload_flag_clr", d, 16'h0040);
  endtask

  // Enables first, then pending status cleared, then power down
  task automatic test_wake();
    wr(gic_pkg::IDX_FEATURE1, 16'h0002);
    wr(gic_pkg::IDX_RISE_EN, 16'h2000);
    check("slot12_tag", {15'h0000, u_gic_host.rx[12]}, 16'h0001);
    check("slot12_set", {15'h0000, u_gic_host.rx[255]}, 16'h0001);
    wr(gic_pkg::IDX_STATUS, 16'hFFFF);
    check("slot12_clr", {15'h0000, u_gic_host.rx[255]}, 16'h0000);
    @(negedge ref_clk);
    pd = 1'h1;
    repeat (20) @(negedge ref_clk);
    txp = 1'h1;
    repeat (12) @(negedge ref_clk);
    check("pd_irq", {15'h0000, irq}, 16'h0001);
    check("wake_up", {15'h0000, sdi}, 16'h0001);
    u_gic_host.wake_ack();
    @(negedge ref_clk);
    check("wake_hold", {15'h0000, sdi}, 16'h0001);
    repeat (12) @(negedge ref_clk);
    check("wake_end", {15'h0000, sdi}, 16'h0000);
    pd = 1'h0;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'h1;
    test_reset();
    test_pins();
    test_edges();
    test_clip();
    test_wake();
    finish_test();
  end

  // About 28 frames of some 3100 cycles each, with margin
  initial begin
    repeat (95000) @(posedge ref_clk);
    fail_count++;
    finish_test();
  end
endmodule // gic_gpio_irq_test
